// File: bench/lbc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none

module lbc_ctrl_tb;
    import lbc_pkg::*;
    typedef struct {lbc_op_t o; logic [1:0] b; logic [12:0] r; logic [8:0] c; logic a; logic [31:0] d;
                    logic [3:0] m;} lbc_row_t;
    logic        sys_clk, rst, user_valid, user_auto_pre, user_ready, user_rvalid, user_asleep;
    logic        cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high, dq_oe, lo;
    lbc_op_t     user_op;
    logic [1:0]  user_bank, byte_write_mask;
    logic [12:0] user_row, addr;
    logic [8:0]  user_col;
    logic [31:0] user_wdata, user_rdata;
    logic [3:0]  user_wmask;
    logic [15:0] dq_out, dq_in;
    int          fail_count = 0, comparisons = 0, rv = 0, nrd = 0, viol, refs, r0, k;
    // Plain transfers: writes carry data, reads carry the word expected back
    lbc_row_t rows [11] = '{
        '{OP_WRITE, 2'h0, 13'h5, 9'h4, 1'h0, 32'h1111_2222, 4'h0},
        '{OP_READ, 2'h0, 13'h5, 9'h4, 1'h0, 32'h1111_2222, 4'h0},
        '{OP_WRITE, 2'h0, 13'h5, 9'h4, 1'h0, 32'haaaa_bbbb, 4'h5},
        '{OP_READ, 2'h0, 13'h5, 9'h4, 1'h1, 32'haa11_bb22, 4'h0},
        '{OP_WRITE, 2'h1, 13'h7, 9'h8, 1'h0, 32'h3333_4444, 4'h0},
        '{OP_WRITE, 2'h0, 13'h9, 9'h0, 1'h0, 32'h5555_6666, 4'h0},
        '{OP_READ, 2'h1, 13'h7, 9'h8, 1'h0, 32'h3333_4444, 4'h0},
        '{OP_READ, 2'h0, 13'h5, 9'h4, 1'h0, 32'haa11_bb22, 4'h0},
        '{OP_WRITE, 2'h3, 13'h1fff, 9'h1fe, 1'h1, 32'h7777_8888, 4'ha},
        '{OP_READ, 2'h3, 13'h1fff, 9'h1fe, 1'h0, 32'hff77_ff88, 4'h0},
        '{OP_READ, 2'h0, 13'h9, 9'h0, 1'h0, 32'h5555_6666, 4'h0}};

    lbc_ctrl i_lbc_ctrl (.sys_clk, .rst, .user_valid, .user_ready, .user_op, .user_bank, .user_row,
        .user_col, .user_auto_pre, .user_wdata, .user_wmask, .user_rdata, .user_rvalid, .user_asleep,
        .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_low, .bank_select_high, .addr,
        .byte_write_mask, .dq_out, .dq_oe, .dq_in);
    lbc_mem_model i_lbc_mem_model (.sys_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_low,
        .bank_select_high, .addr, .byte_write_mask, .dq_out, .dq_oe, .dq_in, .viol, .refs);

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Read answers are one-cycle pulses
    always @(negedge sys_clk) if (user_rvalid === 1'b1) rv++;

    // One request, held until the buffer has room
    task automatic req(input lbc_row_t t);
        @(posedge sys_clk);
        user_valid <= 1'b1;
        user_op <= t.o;
        user_bank <= t.b;
        user_row <= t.r;
        user_col <= t.c;
        user_auto_pre <= t.a;
        user_wdata <= t.d;
        user_wmask <= t.m;
        do @(negedge sys_clk); while (user_ready !== 1'b1);
        @(posedge sys_clk);
        user_valid <= 1'b0;
    endtask

    // Read and compare, answer awaited under a bound
    task automatic rd(input lbc_row_t t);
        req(t);
        nrd++;
        for (int i = 0; i < 300 && rv < nrd; i++) @(negedge sys_clk);
        check(32'(rv >= nrd), 32'h1);
        check(user_rdata, t.d);
    endtask

    task automatic nap(input lbc_op_t o);
        req('{o, 2'h0, 13'h0, 9'h0, 1'h0, 32'h0, 4'h0});
        for (int i = 0; i < 300 && user_asleep !== (o != OP_WAKE); i++) @(negedge sys_clk);
        check({user_asleep, cke}, (o != OP_WAKE) ? 32'h2 : 32'h1);
    endtask

    // Whole run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        tally_and_finish;
    end

    initial begin
        rst = 1'b1;
        user_valid = 1'b0;
        user_op = OP_READ;
        {user_bank, user_row, user_col, user_auto_pre, user_wdata, user_wmask} = '0;
        lo = 1'b0;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        check({cke, cs_n, ras_n, cas_n, we_n, byte_write_mask, dq_oe, user_ready, user_asleep, user_rvalid},
              32'h5f4);
        foreach (rows[i]) begin
            if (rows[i].o == OP_READ) rd(rows[i]);
            else req(rows[i]);
        end
        // Back to back reads until four are taken, noting any refusal in lo
        @(posedge sys_clk);
        user_valid <= 1'b1;
        user_op <= OP_READ;
        {user_bank, user_row, user_col, user_auto_pre} <= {2'h1, 13'h7, 9'h8, 1'h0};
        k = 0;
        while (k < 4) begin
            @(negedge sys_clk);
            if (user_ready === 1'b1) k++;
            else lo = 1'b1;
            @(posedge sys_clk);
        end
        user_valid <= 1'b0;
        // Four reads were taken above, each owes one answer
        nrd += 4;
        rd(rows[6]);
        check(lo, 1'b1);
        // Idle span must still see refreshes
        r0 = refs;
        repeat (400) @(posedge sys_clk);
        check(refs > r0, 1'b1);
        nap(OP_SREF);
        repeat (50) @(posedge sys_clk);
        nap(OP_WAKE);
        rd(rows[6]);
        nap(OP_DPD);
        nap(OP_WAKE);
        rd('{OP_READ, 2'h0, 13'h5, 9'h4, 1'h0, 32'hffff_ffff, 4'h0});
        check(viol, 32'h0);
        tally_and_finish;
    end
endmodule
`default_nettype wire

// File: bench/lbc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "lbc_defines.svh"

// Four-bank memory seen from its pins; counts timing breaches by the controller
module lbc_mem_model (
    input  wire logic        sys_clk,
    input  wire logic        cke,
    input  wire logic        cs_n,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic        bank_select_low,
    input  wire logic        bank_select_high,
    input  wire logic [12:0] addr,
    input  wire logic [1:0]  byte_write_mask,
    input  wire logic [15:0] dq_out,
    input  wire logic        dq_oe,
    output logic [15:0]      dq_in,
    output int               viol,
    output int               refs
);
    logic [15:0] mem [logic [23:0]];
    logic [12:0] row_q [4];
    logic [3:0]  open_b = 4'h0;
    logic [23:0] wk, rk;
    logic [2:0]  rsh = 3'h0;
    logic [1:0]  ba;
    logic        asleep = 1'b0;
    int          t_act [4] = '{default: -99};
    int          t_free [4] = '{default: 0};
    int          tla = -99, tref = 0, trfc = 0, cyc = 0, wph = 0;

    initial begin
        dq_in = 16'h0000;
        viol = 0;
        refs = 0;
    end

    task automatic bad(input string s);
        viol++;
        $display("[ERR] %0t memory model: %s", $time, s);
    endtask

    // Pins sampled on each rising edge
    always @(posedge sys_clk) begin
        cyc++;
        ba = {bank_select_high, bank_select_low};
        // Write elements, mask taken with each element
        if (wph > 0) begin
            if (dq_oe !== 1'b1) bad("write data not driven");
            if (!mem.exists(wk)) mem[wk] = 16'hffff;
            if (!byte_write_mask[0]) mem[wk][7:0] = dq_out[7:0];
            if (!byte_write_mask[1]) mem[wk][15:8] = dq_out[15:8];
            wk[0] = ~wk[0];
            wph--;
        end
        // Read elements CL after the command; otherwise a bus that changes every cycle
        dq_in <= rsh[0] ? (mem.exists(rk) ? mem[rk] : 16'hffff) : ~dq_in;
        if (rsh[0]) rk[0] = ~rk[0];
        rsh = rsh >> 1;
        if (!cke && cyc < trfc) bad("clock enable low in refresh");
        if (!asleep && cyc - tref > 260) begin
            bad("refresh late");
            tref = cyc;
        end
        // Only clock enable matters while asleep
        if (asleep) begin
            if (cke) begin
                asleep = 1'b0;
                tref = cyc;
            end
        end else if (!cs_n) begin
            case ({ras_n, cas_n, we_n})
                3'h3: begin
                    if (open_b[ba]) bad("activate to open bank");
                    if (cyc < t_free[ba]) bad("activate while precharging");
                    if (cyc - t_act[ba] < `LBC_C_RC) bad("same bank activates close");
                    if (cyc - tla < `LBC_C_RRD) bad("bank activates close");
                    open_b[ba] = 1'b1;
                    row_q[ba] = addr;
                    t_act[ba] = cyc;
                    tla = cyc;
                end
                3'h5, 3'h4: begin
                    if (!open_b[ba]) bad("access to idle bank");
                    if (cyc < t_free[ba]) bad("access while precharging");
                    if (cyc - t_act[ba] < `LBC_C_RCD) bad("access too soon");
                    if (we_n) begin
                        rk = {ba, row_q[ba], addr[8:0]};
                        rsh = 3'h6;
                    end else begin
                        wk = {ba, row_q[ba], addr[8:0]};
                        wph = 2;
                    end
                    if (addr[10]) begin
                        open_b[ba] = 1'b0;
                        t_free[ba] = cyc + 2 + `LBC_C_RP;
                    end
                end
                3'h2: for (int b = 0; b < 4; b++) begin
                    if (open_b[b] && (addr[10] || b == ba)) begin
                        open_b[b] = 1'b0;
                        t_free[b] = cyc + `LBC_C_RP;
                    end
                end
                3'h1: begin
                    if (open_b != 4'h0) bad("refresh with open bank");
                    asleep = !cke;
                    trfc = cke ? cyc + `LBC_C_RFC : 0;
                    tref = cyc;
                    refs++;
                end
                3'h6: begin
                    if (!cke) begin
                        mem.delete();
                        asleep = 1'b1;
                    end else rsh = 3'h0;
                end
                default: ;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: src/lbc_buf2.sv
`timescale 1ns/1ps
`default_nettype none

module lbc_buf2 #(
    parameter int W = 64
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              wp;
        logic              rp;
        logic [1:0]        cnt;
        logic              rdy;
    } lbc_buf_t;

    lbc_buf_t q;
    lbc_buf_t d;
    logic     push;
    logic     pop;

    // Handshakes on both sides
    assign push      = in_valid && q.rdy;
    assign pop       = out_valid && out_ready;
    assign in_ready  = q.rdy;
    assign out_valid = (q.cnt != 2'h0);
    assign out_data  = q.mem[q.rp];

    // Pointer and fill bookkeeping
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp        = ~q.wp;
        end
        if (pop) begin
            d.rp = ~q.rp;
        end
        d.cnt = 2'(q.cnt + {1'b0, push} - {1'b0, pop});
        d.rdy = (d.cnt != 2'h2); // Ready drops once both entries hold
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q     <= '0;
            q.rdy <= 1'b1;
        end else begin
            q <= d;
        end
    end
endmodule

`default_nettype wire

// File: src/lbc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "lbc_defines.svh"

module lbc_ctrl (
    input  wire logic            sys_clk,
    input  wire logic            rst,
    input  wire logic            user_valid,
    output logic                 user_ready,
    input  wire lbc_pkg::lbc_op_t user_op,
    input  wire logic [1:0]      user_bank,
    input  wire logic [12:0]     user_row,
    input  wire logic [8:0]      user_col,
    input  wire logic            user_auto_pre,
    input  wire logic [31:0]     user_wdata,
    input  wire logic [3:0]      user_wmask,
    output logic [31:0]          user_rdata,
    output logic                 user_rvalid,
    output logic                 user_asleep,
    output logic                 cke,
    output logic                 cs_n,
    output logic                 ras_n,
    output logic                 cas_n,
    output logic                 we_n,
    output logic                 bank_select_low,
    output logic                 bank_select_high,
    output logic [12:0]          addr,
    output logic [1:0]           byte_write_mask,
    output logic [15:0]          dq_out,
    output logic                 dq_oe,
    input  wire logic [15:0]     dq_in
);
    import lbc_pkg::*;

    localparam int REQ_W = 64;

    lbc_ctrl_t        q;
    lbc_ctrl_t        d;
    logic             req_valid;
    logic             req_pop;
    logic [REQ_W-1:0] req_data;
    logic [1:0]       b;
    logic             set_ref;
    logic             clr_ref;

    // Request buffer between user port and sequencer
    lbc_buf2 #(
        .W(REQ_W)
    ) u_req_buf (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .in_valid (user_valid),
        .in_ready (user_ready),
        .in_data  ({user_op, user_bank, user_row, user_col, user_auto_pre, user_wdata, user_wmask}),
        .out_valid(req_valid),
        .out_ready(req_pop),
        .out_data (req_data)
    );

    // Pins straight from the state register
    assign cke              = q.cke;
    assign cs_n             = q.cmd[3];
    assign ras_n            = q.cmd[2];
    assign cas_n            = q.cmd[1];
    assign we_n             = q.cmd[0];
    assign bank_select_low  = q.ba[0];
    assign bank_select_high = q.ba[1];
    assign addr             = q.addr;
    assign byte_write_mask  = q.mask;
    assign dq_out           = q.dq_out;
    assign dq_oe            = q.dq_oe;
    assign user_rdata       = q.rdata;
    assign user_rvalid      = q.rvalid;
    assign user_asleep      = q.asleep;
    assign b                = q.req_bank;

    // Sequencer next state
    always_comb begin
        d        = q;
        req_pop  = 1'b0;
        set_ref  = 1'b0;
        clr_ref  = 1'b0;
        d.cmd    = `LBC_CMD_NOP;
        d.dq_oe  = 1'b0;
        d.mask   = 2'h3;
        d.rvalid = 1'b0;
        d.dq_s1  = dq_in;
        d.dq_s2  = q.dq_s1;
        // Per-bank row cycle and bank-to-bank timers
        for (int i = 0; i < 4; i++) begin
            if (q.rc_cnt[i] != 4'h0) begin
                d.rc_cnt[i] = 4'(q.rc_cnt[i] - 4'h1);
            end
        end
        if (q.rrd_cnt != 4'h0) begin
            d.rrd_cnt = 4'(q.rrd_cnt - 4'h1);
        end
        // Refresh interval timer, paused while asleep
        if (!q.asleep) begin
            if (q.ref_cnt == 8'h00) begin
                d.ref_cnt = 8'(`LBC_C_REFI - 1);
                set_ref   = 1'b1;
            end else begin
                d.ref_cnt = 8'(q.ref_cnt - 8'h01);
            end
        end
        case (q.st)
            S_IDLE: begin
                if (q.ref_due) begin
                    if (|q.bank_open) begin
                        d.cmd              = `LBC_CMD_PRE;
                        d.addr             = 13'h0000;
                        d.addr[`LBC_A_AP]  = 1'b1;
                        d.bank_open        = 4'h0;
                        d.wait_cnt         = 8'(`LBC_C_RP);
                        d.ret              = S_IDLE;
                        d.st               = S_WAIT;
                    end else begin
                        d.cmd      = `LBC_CMD_REF;
                        d.cke      = 1'b1;
                        clr_ref    = 1'b1;
                        d.wait_cnt = 8'(`LBC_C_RFC);
                        d.ret      = S_IDLE;
                        d.st       = S_WAIT;
                    end
                end else if (req_valid) begin
                    req_pop     = 1'b1;
                    d.req_op    = lbc_op_t'(req_data[63:61]);
                    d.req_bank  = req_data[60:59];
                    d.req_row   = req_data[58:46];
                    d.req_col   = req_data[45:37];
                    d.req_ap    = req_data[36];
                    d.req_wdata = req_data[35:4];
                    d.req_wmask = req_data[3:0];
                    d.st        = (lbc_op_t'(req_data[63:61]) == OP_WAKE) ? S_IDLE : S_PLAN;
                end
            end
            S_PLAN: begin
                if (q.req_op == OP_READ || q.req_op == OP_WRITE) begin
                    if (q.bank_open[b] && q.bank_row[b] == q.req_row) begin
                        d.cmd  = (q.req_op == OP_READ) ? `LBC_CMD_READ : `LBC_CMD_WRITE;
                        d.ba   = b;
                        d.addr = {2'h0, q.req_ap, 1'b0, q.req_col};
                        d.ph   = 4'h0;
                        d.st   = (q.req_op == OP_READ) ? S_RDATA : S_WDATA;
                        if (q.req_ap) begin
                            d.bank_open[b] = 1'b0;
                        end
                    end else if (q.bank_open[b]) begin
                        d.cmd          = `LBC_CMD_PRE;
                        d.ba           = b;
                        d.addr         = 13'h0000;
                        d.bank_open[b] = 1'b0;
                        d.wait_cnt     = 8'(`LBC_C_RP);
                        d.ret          = S_PLAN;
                        d.st           = S_WAIT;
                    end else if (q.rc_cnt[b] == 4'h0 && q.rrd_cnt == 4'h0) begin
                        d.cmd          = `LBC_CMD_ACT;
                        d.ba           = b;
                        d.addr         = q.req_row;
                        d.bank_open[b] = 1'b1;
                        d.bank_row[b]  = q.req_row;
                        d.rc_cnt[b]    = 4'(`LBC_C_RC);
                        d.rrd_cnt      = 4'(`LBC_C_RRD);
                        d.wait_cnt     = 8'(`LBC_C_RCD);
                        d.ret          = S_PLAN;
                        d.st           = S_WAIT;
                    end
                end else if (|q.bank_open) begin
                    d.cmd             = `LBC_CMD_PRE;
                    d.addr            = 13'h0000;
                    d.addr[`LBC_A_AP] = 1'b1;
                    d.bank_open       = 4'h0;
                    d.wait_cnt        = 8'(`LBC_C_RP);
                    d.ret             = S_PLAN;
                    d.st              = S_WAIT;
                end else if (q.req_op == OP_SREF) begin
                    d.cmd    = `LBC_CMD_REF; // Self refresh entry
                    d.cke    = 1'b0;
                    d.asleep = 1'b1;
                    d.st     = S_SREF;
                end else begin
                    d.cmd    = `LBC_CMD_BST; // Deep power-down entry
                    d.cke    = 1'b0;
                    d.asleep = 1'b1;
                    d.st     = S_DPD;
                end
            end
            S_WAIT: begin
                if (q.wait_cnt <= 8'h01) begin
                    d.st = q.ret;
                end else begin
                    d.wait_cnt = 8'(q.wait_cnt - 8'h01);
                end
            end
            S_WDATA: begin
                d.dq_oe = 1'b1;
                if (q.ph == 4'h0) begin
                    d.dq_out = q.req_wdata[15:0];
                    d.mask   = q.req_wmask[1:0];
                    d.ph     = 4'h1;
                end else begin
                    d.dq_out   = q.req_wdata[31:16];
                    d.mask     = q.req_wmask[3:2];
                    d.wait_cnt = 8'(`LBC_C_WR + `LBC_C_RP);
                    d.ret      = S_IDLE;
                    d.st       = S_WAIT;
                end
            end
            S_RDATA: begin
                d.ph = 4'(q.ph + 4'h1);
                if (q.ph == 4'(`LBC_RD_CAP)) begin
                    d.rd_lo = q.dq_s2;
                end else if (q.ph == 4'(`LBC_RD_CAP + 1)) begin
                    d.rdata    = {q.dq_s2, q.rd_lo};
                    d.rvalid   = 1'b1;
                    d.wait_cnt = 8'(`LBC_C_RP);
                    d.ret      = S_IDLE;
                    d.st       = q.req_ap ? S_WAIT : S_IDLE;
                end
            end
            S_SREF, S_DPD: begin
                // Only a wake request leaves; anything else is dropped
                if (req_valid) begin
                    req_pop = 1'b1;
                    if (lbc_op_t'(req_data[63:61]) == OP_WAKE) begin
                        d.cke      = 1'b1;
                        d.asleep   = 1'b0;
                        set_ref    = 1'b1;
                        d.ref_cnt  = 8'(`LBC_C_REFI - 1);
                        d.wait_cnt = 8'(`LBC_C_XSR);
                        d.ret      = S_IDLE;
                        d.st       = S_WAIT;
                    end
                end
            end
            default: begin
                d.st = S_IDLE;
            end
        endcase
        // A new due refresh wins over the clear of the old one
        d.ref_due = set_ref || (q.ref_due && !clr_ref);
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q         <= '0;
            q.st      <= S_IDLE;
            q.ret     <= S_IDLE;
            q.cke     <= 1'b1;
            q.cmd     <= `LBC_CMD_NOP;
            q.mask    <= 2'h3;
            q.ref_cnt <= 8'(`LBC_C_REFI - 1);
        end else begin
            q <= d;
        end
    end

    // Pin command decode and spacing counters for checking
    localparam int REF_SLACK = `LBC_C_REFI + 40;
    logic       is_act;
    logic       is_rw;
    logic       is_ref;
    logic       is_pre;
    logic [7:0] since_act;
    logic [7:0] since_pre;
    logic [8:0] since_ref;
    assign is_act = cke && q.cmd == `LBC_CMD_ACT;
    assign is_rw  = cke && (q.cmd == `LBC_CMD_READ || q.cmd == `LBC_CMD_WRITE);
    assign is_ref = cke && q.cmd == `LBC_CMD_REF;
    assign is_pre = q.cmd == `LBC_CMD_PRE;

    // Distance counters; since_act and since_pre saturate, since_ref wraps
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            since_act <= 8'hff;
            since_pre <= 8'hff;
            since_ref <= 9'h000;
        end else begin
            since_act <= is_act ? 8'h00 : ((since_act == 8'hff) ? since_act : 8'(since_act + 8'h01));
            since_pre <= is_pre ? 8'h00 : ((since_pre == 8'hff) ? since_pre : 8'(since_pre + 8'h01));
            since_ref <= (is_ref || q.asleep) ? 9'h000 : 9'(since_ref + 9'h001);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_wr_lo;
        dq_oe && byte_write_mask == q.req_wmask[1:0] && dq_out == q.req_wdata[15:0];
    endsequence
    sequence s_wr_hi;
        dq_oe && byte_write_mask == q.req_wmask[3:2] && dq_out == q.req_wdata[31:16];
    endsequence

    a_act_bank_closed: assert property (is_act |-> $past(!q.bank_open[q.req_bank]))
        else $error("activate to a bank with an open row");
    a_rw_row_open: assert property (is_rw |-> $past(q.bank_open[q.req_bank] && q.bank_row[q.req_bank] == q.req_row))
        else $error("access without the matching open row");
    a_rcd_spacing: assert property (is_rw |-> since_act >= 8'(`LBC_C_RCD))
        else $error("access too soon after activate");
    a_rp_spacing: assert property ((is_act || is_ref) |-> since_pre >= 8'(`LBC_C_RP))
        else $error("command too soon after precharge");
    a_rrd_spacing: assert property (is_act |-> since_act >= 8'(`LBC_C_RRD))
        else $error("activates too close together");
    a_rc_spacing: assert property (is_act |-> $past(q.rc_cnt[q.req_bank]) == 4'h0)
        else $error("same-bank activates too close");
    a_ref_idle: assert property (is_ref |-> $past(q.bank_open) == 4'h0)
        else $error("refresh with a bank open");
    a_ref_cke: assert property (is_ref |-> cke ##1 cke [*2])
        else $error("clock enable dropped during refresh");
    a_ref_interval: assert property (since_ref <= 9'(REF_SLACK))
        else $error("refresh interval overrun");
    a_wr_mask: assert property ((cke && q.cmd == `LBC_CMD_WRITE) |=> s_wr_lo ##1 s_wr_hi)
        else $error("write data or mask out of place");
    a_ap_hold: assert property ((is_rw && addr[`LBC_A_AP]) |=> !(is_act || is_rw) [*3])
        else $error("command too soon after auto precharge");
endmodule

`default_nettype wire

// File: src/lbc_defines.svh
`ifndef LBC_DEFINES_SVH
`define LBC_DEFINES_SVH

// Clock period in picoseconds (25 MHz)
`define LBC_CLK_PS      40000

// Memory timing figures in their own units
`define LBC_T_RCD_NS    20
`define LBC_T_RP_NS     20
`define LBC_T_RC_NS     70
`define LBC_T_RRD_NS    15
`define LBC_T_RFC_NS    80
`define LBC_T_XSR_NS    120
`define LBC_T_WR_NS     15
`define LBC_T_REFI_PS   7812500

// Least times round up to whole cycles
`define LBC_C_RCD       ((`LBC_T_RCD_NS * 1000 + `LBC_CLK_PS - 1) / `LBC_CLK_PS)
`define LBC_C_RP        ((`LBC_T_RP_NS * 1000 + `LBC_CLK_PS - 1) / `LBC_CLK_PS)
`define LBC_C_RC        ((`LBC_T_RC_NS * 1000 + `LBC_CLK_PS - 1) / `LBC_CLK_PS)
`define LBC_C_RRD       ((`LBC_T_RRD_NS * 1000 + `LBC_CLK_PS - 1) / `LBC_CLK_PS)
`define LBC_C_RFC       ((`LBC_T_RFC_NS * 1000 + `LBC_CLK_PS - 1) / `LBC_CLK_PS)
`define LBC_C_XSR       ((`LBC_T_XSR_NS * 1000 + `LBC_CLK_PS - 1) / `LBC_CLK_PS)
`define LBC_C_WR        ((`LBC_T_WR_NS * 1000 + `LBC_CLK_PS - 1) / `LBC_CLK_PS)
// Longest time rounds down
`define LBC_C_REFI      (`LBC_T_REFI_PS / `LBC_CLK_PS)

// Read data path
`define LBC_CAS_LAT     3
`define LBC_RD_CAP      (`LBC_CAS_LAT + 2)

// Address bit that carries auto precharge / all-bank precharge
`define LBC_A_AP        10

// Command pin codes {cs_n, ras_n, cas_n, we_n}
`define LBC_CMD_NOP     4'h7
`define LBC_CMD_ACT     4'h3
`define LBC_CMD_READ    4'h5
`define LBC_CMD_WRITE   4'h4
`define LBC_CMD_PRE     4'h2
`define LBC_CMD_REF     4'h1
`define LBC_CMD_BST     4'h6

`endif

// File: src/lbc_pkg.sv
package lbc_pkg;

    // User operations
    typedef enum logic [2:0] {
        OP_READ  = 3'h0,
        OP_WRITE = 3'h1,
        OP_SREF  = 3'h2,
        OP_DPD   = 3'h3,
        OP_WAKE  = 3'h4
    } lbc_op_t;

    // Sequencer states
    typedef enum logic [6:0] {
        S_IDLE  = 7'h01,
        S_PLAN  = 7'h02,
        S_WAIT  = 7'h04,
        S_WDATA = 7'h08,
        S_RDATA = 7'h10,
        S_SREF  = 7'h20,
        S_DPD   = 7'h40
    } lbc_state_t;

    // Whole controller state
    typedef struct packed {
        lbc_state_t       st;
        lbc_state_t       ret;
        logic [7:0]       wait_cnt;
        logic [7:0]       ref_cnt;
        logic             ref_due;
        logic [3:0]       rrd_cnt;
        logic [3:0][3:0]  rc_cnt;
        logic [3:0]       bank_open;
        logic [3:0][12:0] bank_row;
        lbc_op_t          req_op;
        logic [1:0]       req_bank;
        logic [12:0]      req_row;
        logic [8:0]       req_col;
        logic             req_ap;
        logic [31:0]      req_wdata;
        logic [3:0]       req_wmask;
        logic [3:0]       ph;
        logic [15:0]      rd_lo;
        logic [31:0]      rdata;
        logic             rvalid;
        logic             asleep;
        logic             cke;
        logic [3:0]       cmd;
        logic [1:0]       ba;
        logic [12:0]      addr;
        logic [1:0]       mask;
        logic [15:0]      dq_out;
        logic             dq_oe;
        logic [15:0]      dq_s1;
        logic [15:0]      dq_s2;
    } lbc_ctrl_t;

endpackage
